// File: pkg/afc_pkg.sv
// constants for the serial frame and conversion sequencer
// assumes one 40 mhz system clock samples all serial pins
package afc_pkg;
  localparam int          RESULT_W    = 12;    // result width
  localparam int          CNT_W       = 5;     // edge counter width
  localparam int          CTRL_W      = 8;     // control word width
  localparam int          CH_W        = 3;     // channel code width
  localparam int          CH_LSB      = 3;     // channel code low bit
  localparam int          SYNC_N      = 3;     // synchronised pins
  localparam logic [4:0]  CONV_EDGES  = 5'h10; // edges per conversion
  localparam logic [4:0]  TRACK_LAST  = 5'h03; // last tracking fall
  localparam logic [4:0]  HOLD_FALL   = 5'h04; // fall entering hold
  localparam logic [4:0]  CTRL_RISES  = 5'h08; // rises carrying control
  localparam logic [4:0]  CNT_ONE     = 5'h01; // counter step
  localparam logic [4:0]  CNT_ZERO    = 5'h00; // counter clear
  localparam logic [7:0]  CTRL_RST    = 8'h00; // control reset value
  localparam logic [2:0]  CH_RST      = 3'h0;  // analog_input_zero
  localparam logic [11:0] RES_RST     = 12'h000; // result reset value
  localparam int          PIN_CS      = 0;     // sync index chip select
  localparam int          PIN_SCLK    = 1;     // sync index serial clock
  localparam int          PIN_DIN     = 2;     // sync index control in
  localparam logic [2:0]  PIN_RST     = 3'h1;  // pin levels at reset, select high, clock low
  localparam int          SCLK_NS     = 200;   // bench serial clock period
  localparam int          CLK_NS      = 25;    // system clock period
  typedef enum logic [1:0] {
    AFC_IDLE,
    AFC_WAIT_FALL,
    AFC_CONVERT
  } afc_state_t;
endpackage

// File: rtl/afc_frame_ctrl.sv
// serial frame and conversion sequencer of the converter
// assumes the analog core presents its result on conv_result
`timescale 1ns/100ps
module afc_frame_ctrl
  import afc_pkg::*;
(
  input  wire logic                         clk,         // system clock
  input  wire logic                         resetn,      // sync, active low
  input  wire logic                         cs_n,        // chip select pin
  input  wire logic                         sclk,        // serial clock pin
  input  wire logic                         din,         // control input
  input  wire logic [afc_pkg::RESULT_W-1:0] conv_result, // core result
  output logic                              dout,        // result output
  output logic                              dout_oe_n,   // low drives dout
  output logic [afc_pkg::CH_W-1:0]          mux_sel,     // input channel
  output logic                              track_en,    // sampling input
  output logic                              hold_en,     // hold/convert
  output logic                              powered_up   // core powered
);
  import afc_pkg::*;

  logic [SYNC_N-1:0] p_lvl, p_rise, p_fall;   // synchronised pins
  afc_state_t           st_ff, nxt_st;        // frame state
  logic [CNT_W-1:0]     fall_ff, nxt_fall;    // falls in conversion
  logic [CNT_W-1:0]     rise_ff, nxt_rise;    // rises in conversion
  logic [CTRL_W-1:0]    ctrl_ff, nxt_ctrl;    // channel_select_control
  logic [CH_W-1:0]      pend_ff, nxt_pend;    // code for next conversion
  logic [CH_W-1:0]      chan_ff, nxt_chan;    // code in use
  logic [RESULT_W-1:0]  res_ff, nxt_res;      // result shifter
  logic                 dout_ff, nxt_dout;    // output bit
  logic                 oe_n_ff, nxt_oe_n;    // output enable, low drives
  logic                 trk_ff, nxt_trk;      // tracking
  logic                 hld_ff, nxt_hld;      // holding
  logic                 pwr_ff, nxt_pwr;      // powered

  // pins cross into clk domain
  afc_pin_sync #(
    .N       (SYNC_N),
    .RST_LVL (PIN_RST)
  ) u_sync (
    .clk    (clk),
    .resetn (resetn),
    .pin_in ({din, sclk, cs_n}),
    .lvl    (p_lvl),
    .rise   (p_rise),
    .fall   (p_fall)
  );

  // next state of the sequencer
  always_comb begin
    logic [CNT_W-1:0]  k;    // number of the edge in hand
    logic [CTRL_W-1:0] sh;   // control word after shift
    k        = CNT_ZERO;
    sh       = ctrl_ff;
    nxt_st   = st_ff;
    nxt_fall = fall_ff;
    nxt_rise = rise_ff;
    nxt_ctrl = ctrl_ff;
    nxt_pend = pend_ff;
    nxt_chan = chan_ff;
    nxt_res  = res_ff;
    nxt_dout = dout_ff;
    nxt_oe_n = oe_n_ff;
    nxt_trk  = trk_ff;
    nxt_hld  = hld_ff;
    nxt_pwr  = pwr_ff;
    case (st_ff)
      AFC_IDLE: begin
        // frame opens on chip select fall
        if (p_fall[PIN_CS]) begin
          nxt_oe_n = 1'b0;
          nxt_dout = 1'b0;
          nxt_fall = CNT_ZERO;
          nxt_rise = CNT_ZERO;
          if (!p_lvl[PIN_SCLK]) begin
            // clock already low or falling now is fall one
            nxt_st   = AFC_CONVERT;
            nxt_fall = CNT_ONE;
            nxt_trk  = 1'b1;
            nxt_pwr  = 1'b1;
          end else begin
            nxt_st   = AFC_WAIT_FALL;
          end
        end
      end
      AFC_WAIT_FALL: begin
        if (p_rise[PIN_CS]) begin
          nxt_st = AFC_IDLE;
        end else if (p_fall[PIN_SCLK]) begin
          // first clock fall starts tracking
          nxt_st   = AFC_CONVERT;
          nxt_fall = CNT_ONE;
          nxt_trk  = 1'b1;
          nxt_pwr  = 1'b1;
        end
      end
      AFC_CONVERT: begin
        if (p_rise[PIN_CS]) begin
          nxt_st = AFC_IDLE;
        end else if (p_fall[PIN_SCLK]) begin
          k        = fall_ff + CNT_ONE;
          nxt_fall = k;
          if (k <= TRACK_LAST) begin
            // tracking falls, leading zeros; fall one restarts
            nxt_trk  = 1'b1;
            nxt_hld  = 1'b0;
            nxt_pwr  = 1'b1;
            nxt_dout = 1'b0;
          end else if (k == HOLD_FALL) begin
            // sample is held, straight binary result taken
            nxt_trk  = 1'b0;
            nxt_hld  = 1'b1;
            nxt_res  = conv_result;
            nxt_dout = 1'b0;
          end else begin
            // result bits, msb first
            nxt_dout = res_ff[RESULT_W-1];
            nxt_res  = {res_ff[RESULT_W-2:0], 1'b0};
            if (k == CONV_EDGES) begin
              nxt_hld = 1'b0;
              nxt_pwr = 1'b0;
            end
          end
        end else if (p_rise[PIN_SCLK]) begin
          k        = rise_ff + CNT_ONE;
          nxt_rise = k;
          if (k <= CTRL_RISES) begin
            // control word shifted in, msb first
            sh       = {ctrl_ff[CTRL_W-2:0], p_lvl[PIN_DIN]};
            nxt_ctrl = sh;
            if (k == CTRL_RISES) begin
              nxt_pend = sh[CH_LSB+CH_W-1:CH_LSB];
            end
          end
          if (k == CONV_EDGES) begin
            // conversion done: next fall is fall one
            nxt_chan = pend_ff;
            nxt_fall = CNT_ZERO;
            nxt_rise = CNT_ZERO;
          end
        end
      end
      default: begin
        nxt_st = AFC_IDLE;
      end
    endcase
    if (nxt_st == AFC_IDLE) begin
      // outside a frame: released, unpowered, clock ignored
      nxt_oe_n = 1'b1;
      nxt_dout = 1'b0;
      nxt_trk  = 1'b0;
      nxt_hld  = 1'b0;
      nxt_pwr  = 1'b0;
      nxt_fall = CNT_ZERO;
      nxt_rise = CNT_ZERO;
    end
  end

  // sequencer registers; channel keeps its code across frames
  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_ff   <= AFC_IDLE;
      fall_ff <= CNT_ZERO;
      rise_ff <= CNT_ZERO;
      ctrl_ff <= CTRL_RST;
      pend_ff <= CH_RST;
      chan_ff <= CH_RST;
      res_ff  <= RES_RST;
      dout_ff <= 1'b0;
      oe_n_ff <= 1'b1;
      trk_ff  <= 1'b0;
      hld_ff  <= 1'b0;
      pwr_ff  <= 1'b0;
    end else begin
      st_ff   <= nxt_st;
      fall_ff <= nxt_fall;
      rise_ff <= nxt_rise;
      ctrl_ff <= nxt_ctrl;
      pend_ff <= nxt_pend;
      chan_ff <= nxt_chan;
      res_ff  <= nxt_res;
      dout_ff <= nxt_dout;
      oe_n_ff <= nxt_oe_n;
      trk_ff  <= nxt_trk;
      hld_ff  <= nxt_hld;
      pwr_ff  <= nxt_pwr;
    end
  end

  // outputs straight from flip-flops
  assign dout       = dout_ff;
  assign dout_oe_n  = oe_n_ff;
  assign mux_sel    = chan_ff;
  assign track_en   = trk_ff;
  assign hold_en    = hld_ff;
  assign powered_up = pwr_ff;
endmodule

// File: rtl/afc_pin_sync.sv
// three stage pin synchroniser with level filter and edge pulses
// assumes pins are asynchronous to clk; reset levels are constants
`timescale 1ns/100ps
module afc_pin_sync #(
  parameter int         N       = 3,    // number of pins
  parameter logic [2:0] RST_LVL = 3'h0  // filtered level at reset
) (
  input  wire logic         clk,     // system clock
  input  wire logic         resetn,  // sync reset, active low
  input  wire logic [N-1:0] pin_in,  // raw pin levels
  output logic      [N-1:0] lvl,     // filtered level
  output logic      [N-1:0] rise,    // one cycle on accepted rise
  output logic      [N-1:0] fall     // one cycle on accepted fall
);
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_pin
      logic s1_ff, s2_ff, s3_ff;           // synchroniser chain
      logic lvl_ff, rise_ff, fall_ff;      // filtered state
      logic nxt_lvl, nxt_rise, nxt_fall;   // next values
      // accept a change once stages two and three agree
      always_comb begin
        nxt_lvl  = lvl_ff;
        nxt_rise = 1'b0;
        nxt_fall = 1'b0;
        if ((s2_ff == s3_ff) && (s3_ff != lvl_ff)) begin
          nxt_lvl  = s3_ff;
          nxt_rise = s3_ff;
          nxt_fall = ~s3_ff;
        end
      end
      // register chain and filtered level
      always_ff @(posedge clk) begin
        if (!resetn) begin
          s1_ff   <= RST_LVL[g];
          s2_ff   <= RST_LVL[g];
          s3_ff   <= RST_LVL[g];
          lvl_ff  <= RST_LVL[g];
          rise_ff <= 1'b0;
          fall_ff <= 1'b0;
        end else begin
          s1_ff   <= pin_in[g];
          s2_ff   <= s1_ff;
          s3_ff   <= s2_ff;
          lvl_ff  <= nxt_lvl;
          rise_ff <= nxt_rise;
          fall_ff <= nxt_fall;
        end
      end
      assign lvl[g]  = lvl_ff;
      assign rise[g] = rise_ff;
      assign fall[g] = fall_ff;
    end
  endgenerate
endmodule

// File: tb/afc_frame_ctrl_sva.sv
// port checks for the serial frame sequencer
// assumes a bind from the bench top; one clock domain
`timescale 1ns/100ps
module afc_frame_ctrl_sva
  import afc_pkg::*;
(
  input wire logic                clk,        // system clock
  input wire logic                resetn,     // sync reset, low
  input wire logic                cs_n,       // chip select pin
  input wire logic                sclk,       // serial clock pin
  input wire logic                dout,       // result bit
  input wire logic                dout_oe_n,  // low drives dout
  input wire logic [CH_W-1:0]     mux_sel,    // channel in use
  input wire logic                track_en,   // tracking
  input wire logic                hold_en,    // hold/convert
  input wire logic                powered_up  // core powered
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // start of tracking and of hold
  sequence s_trk_on;
    $rose(track_en);
  endsequence
  sequence s_hld_on;
    $rose(hold_en);
  endsequence
  // select idle for eight clocks
  sequence s_quiet;
    cs_n [*8];
  endsequence
  a_oe_release: assert property ($rose(cs_n) |-> ##[2:6] dout_oe_n)
    else $error("dout not released after select rise");
  a_oe_quiet: assert property (s_quiet |-> dout_oe_n && !dout)
    else $error("dout driven outside frame");
  a_idle_down: assert property (
    s_quiet |-> !powered_up && !track_en)
    else $error("activity outside frame");
  a_low_start: assert property (
    $fell(cs_n) && !sclk |-> ##[2:7] track_en)
    else $error("no tracking after select fall with clock low");
  a_trk_len: assert property (s_trk_on |-> track_en [*8])
    else $error("tracking too short");
  a_trk_end: assert property (s_trk_on |-> ##[22:26] hold_en)
    else $error("hold not entered after three cycles");
  a_hold_src: assert property (s_hld_on |-> $past(track_en))
    else $error("hold entered without tracking");
  a_one_mode: assert property (!(track_en && hold_en))
    else $error("track and hold together");
  a_pwr_on: assert property (track_en || hold_en |-> powered_up)
    else $error("converting while powered down");
  a_lead_zero: assert property (track_en |-> !dout)
    else $error("nonzero bit while tracking");
  a_code_wait: assert property (
    !$stable(mux_sel) |-> !hold_en && !track_en)
    else $error("channel changed inside conversion");
endmodule

// File: tb/afc_frame_ctrl_test.sv
// bench for the frame sequencer with a host model
// assumes the package constants; analog core modelled here
`timescale 1ns/100ps
module afc_frame_ctrl_test;
  import afc_pkg::*;
  logic                clk, resetn, cs_n, sclk, din;
  logic                dout, dout_oe_n, track_en, hold_en, powered_up;
  logic [RESULT_W-1:0] conv_result;
  logic [CH_W-1:0]     mux_sel;
  wire                 dpin;
  int                  num_errors = 0;
  int                  checks = 0;
  logic [31:0]         seed = 32'h98DA;
  logic [11:0]         ana [8]; // analog input levels
  logic [2:0]          ch = 3'h0; // expected channel
  assign dpin = dout_oe_n ? 1'bz : dout;
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // analog core: level of the selected input
  always @(posedge clk) #1 conv_result = ana[mux_sel];
  afc_frame_ctrl afc_frame_ctrl_i (.clk(clk), .resetn(resetn),
    .cs_n(cs_n), .sclk(sclk), .din(din), .conv_result(conv_result),
    .dout(dout), .dout_oe_n(dout_oe_n), .mux_sel(mux_sel),
    .track_en(track_en), .hold_en(hold_en), .powered_up(powered_up));
  afc_host_model afc_host_model_i (.clk(clk), .dout(dpin),
    .trk(track_en), .hld(hold_en), .pwr(powered_up),
    .cs_n(cs_n), .sclk(sclk), .din(din));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one full conversion, ignored bits random
  task automatic cv(input logic [2:0] code);
    logic [15:0] r, t, h, p;
    logic [31:0] x;
    x = xs();
    afc_host_model_i.conv({x[7:6], code, x[2:0]}, 16, r, t, h, p);
    chk(r, {4'h0, ana[ch]});
    chk(t, 16'hE000);
    chk(h, 16'h1FFE);
    chk(p, 16'hFFFE);
    ch = code;
  endtask
  task automatic conclude();
    if (num_errors == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (6000) @(posedge clk);
    num_errors++;
    conclude();
  end
  initial begin
    logic [15:0] d;
    resetn = 1'b0;
    foreach (ana[i]) ana[i] = 12'(xs());
    repeat (3) @(posedge clk);
    #1 resetn = 1'b1;
    afc_host_model_i.stray();
    chk(16'(dout_oe_n), 16'h0001);
    chk(16'(mux_sel), 16'h0000);
    afc_host_model_i.open(0);
    chk(16'(dout_oe_n), 16'h0000);
    for (int i = 0; i < 9; i++) cv(3'(i + 1));
    afc_host_model_i.close();
    chk(16'(dout_oe_n), 16'h0001);
    for (int m = 1; m < 3; m++) begin
      foreach (ana[i]) ana[i] = 12'(xs());
      afc_host_model_i.open(m);
      cv(3'(xs()));
      cv(3'(xs()));
      afc_host_model_i.close();
    end
    afc_host_model_i.open(0);
    afc_host_model_i.conv({2'h0, ~ch, 3'h0}, 10, d, d, d, d);
    afc_host_model_i.close();
    afc_host_model_i.open(0);
    cv(3'(xs()));
    afc_host_model_i.close();
    conclude();
  end
endmodule
bind afc_frame_ctrl afc_frame_ctrl_sva afc_frame_ctrl_sva_i (.clk(clk),
  .resetn(resetn), .cs_n(cs_n), .sclk(sclk), .dout(dout),
  .dout_oe_n(dout_oe_n), .mux_sel(mux_sel), .track_en(track_en),
  .hold_en(hold_en), .powered_up(powered_up));

// File: tb/afc_host_model.sv
// host serial controller model making frames and clocks
// assumes the bench calls its tasks; clk is the system clock
`timescale 1ns/100ps
module afc_host_model (
  input  wire logic clk,   // system clock
  input  wire logic dout,  // result pin on the wire
  input  wire logic trk,   // tracking status
  input  wire logic hld,   // hold status
  input  wire logic pwr,   // power status
  output logic      cs_n,  // chip select
  output logic      sclk,  // serial clock
  output logic      din    // control bits
);
  // idle pins; link clock stands still high
  initial begin
    cs_n = 1'b1;
    sclk = 1'b1;
    din  = 1'b0;
  end
  // wait clocks, then step off the edge
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // clock activity with select high
  task automatic stray();
    repeat (4) begin
      sclk = ~sclk;
      din  = ~din;
      wt(4);
    end
  endtask
  // mode 0 clock high, 1 clock low, 2 both fall
  task automatic open(input int mode);
    if (mode == 1) begin
      sclk = 1'b0;
      wt(4);
    end
    cs_n = 1'b0;
    if (mode == 2)
      sclk = 1'b0;
    // modes 1 and 2: select fall is fall one, first rise must
    // follow after the normal half period, so no extra wait
    // mode 0: let the select fall reach the outputs, six clocks
    if (mode == 0)
      wt(6);
  endtask
  // n clocks of one conversion; capture pin and status per fall
  task automatic conv(input logic [7:0] w, input int n,
                      output logic [15:0] r, t, h, p);
    for (int k = 1; k <= n; k++) begin
      if (sclk)
        sclk = 1'b0;
      din = (k <= 8) ? w[8-k] : ~din;
      wt(4);
      sclk = 1'b1;
      wt(4);
      r[16-k] = dout;
      t[16-k] = trk;
      h[16-k] = hld;
      p[16-k] = pwr;
    end
  endtask
  // end frame, clock left high
  task automatic close();
    wt(2);
    cs_n = 1'b1;
    wt(8);
  endtask
endmodule
